// [rtl/mbo_regs.vh]
// Constants for the matrix bit operation unit.
// Assumes inclusion by bare name from the design files.
`ifndef MBO_REGS_VH
`define MBO_REGS_VH
`define MBO_OP_EQV 3'h0
`define MBO_OP_INV 3'h1
`define MBO_OP_CMP 3'h2
`define MBO_OP_BRD 3'h3
`define MBO_OP_BWR 3'h4
`define MBO_ST_IDLE 3'h0
`define MBO_ST_RDA 3'h1
`define MBO_ST_RDB 3'h2
`define MBO_ST_WR 3'h3
`define MBO_ST_BRD 3'h4
`define MBO_ST_DONE 3'h5
`define MBO_WORD_BITS 16
`define MBO_BIT_IDX_W 4
`define MBO_MIN_LEN 2
`endif

// [rtl/mbo_edge.v]
// Enable qualifier: level form or rising-edge form.
// Assumes i_en synchronous to the clock.
`timescale 1ns/1ps
module mbo_edge (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_en,
  input wire i_pulse_mode,
  output wire o_fire
);
  reg en_q;
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_q <= 1'b0;
    end else begin
      en_q <= i_en;
    end
  end
  assign o_fire = i_pulse_mode ? (i_en & ~en_q) : i_en;
endmodule // mbo_edge

// [rtl/mbo_matrix_unit.v]
// Bit-matrix operation unit: equivalence, complement, compare search, bit read and bit write.
// Assumes a word data memory with one-cycle read latency and a sequencer holding inputs stable while busy.
`timescale 1ns/1ps
`include "mbo_regs.vh"

// Overview of operation
// - Matrix is L consecutive 16-bit words, L at least two.
// - Enable runs the operation as a level or only on its rising edge.
// - Equivalence gives one where both source bits agree, zero otherwise.
// - Equivalence pairs equal indices over all bits into equal-length destination.
// - Complement inverts every bit of source into destination.
// - Search starts at zero if from-top or pointer at last, else pointer plus one.
// - Select one seeks differing pairs, zero seeks equal pairs.
// - On a match pointer takes its index and found flag sets.
// - Reaching last pair ends, sets end flag, pointer stays last; next run restarts.
// - Pointer out of range sets error flag and suppresses compare, read, write.
// - Bit read puts the pointed bit onto the read-out output.
// - Bit read clears the pointer first when pointer-zero input is high.
// - After read, end flag if pointer last, else step increments pointer.
// - Pointer-zero input clears pointer on its own while idle; a pointer load or an enable starting equivalence, complement or compare blocks it.
// - Bit write stores the write value bit at the pointed position.
// - Bit write clears the pointer first when pointer-zero input is high.
// - After write, end flag if pointer last, else step increments; no flag by incrementing.
module mbo_matrix_unit #(
  parameter AW = 16,
  parameter PW = 16
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_en,
  input wire i_pulse_mode,
  input wire [2:0] i_op,
  input wire [AW-1:0] i_source_a_base,
  input wire [AW-1:0] i_source_b_base,
  input wire [AW-1:0] i_destination_base,
  input wire [PW-1:0] i_len,
  input wire i_search_from_top,
  input wire i_differ_sel,
  input wire i_write_value_bit,
  input wire i_step,
  input wire i_pointer_zero_input,
  input wire i_ptr_load,
  input wire [PW-1:0] i_ptr_load_val,
  input wire [15:0] i_mem_rdata,
  output reg o_mem_rd,
  output reg o_mem_wr,
  output reg [AW-1:0] o_mem_addr,
  output reg [15:0] o_mem_wdata,
  output reg [PW-1:0] o_bit_pointer,
  output reg o_match_found_flag,
  output reg o_end_flag,
  output reg o_ptr_error_flag,
  output reg o_read_out_bit,
  output reg o_busy,
  output reg o_done
);
  wire fire;
  reg [2:0] st_q;
  reg [2:0] op_q;
  reg [PW-1:0] widx_q;
  reg [PW-1:0] cur_q;
  reg [15:0] worda_q;
  reg [15:0] wordb_q;
  reg held_q;
  reg wrap_q;
  wire [PW+3:0] nbits = {i_len, 4'h0};
  wire [PW-1:0] last_idx = nbits[PW-1:0] - {{(PW-1){1'b0}}, 1'b1};
  wire len_ok = i_len >= `MBO_MIN_LEN;
  wire [PW-1:0] cur_word = cur_q >> `MBO_BIT_IDX_W;
  wire [3:0] cur_bit = cur_q[3:0];
  wire [PW-1:0] ptr_eff = i_pointer_zero_input ? {PW{1'b0}} : o_bit_pointer;
  wire ptr_bad = ptr_eff > last_idx;
  wire [PW-1:0] ptr_inc = ptr_eff + {{(PW-1){1'b0}}, 1'b1};
  // Memory data stand for one cycle only, so a scanned word is held locally.
  wire [15:0] b_word = held_q ? wordb_q : i_mem_rdata;
  wire pair_hit = i_differ_sel ? (worda_q[cur_bit] != b_word[cur_bit])
                               : (worda_q[cur_bit] == b_word[cur_bit]);
  wire [15:0] sel_mask = 16'h0001 << cur_bit;

  mbo_edge u_edge (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_en(i_en),
    .i_pulse_mode(i_pulse_mode),
    .o_fire(fire)
  );

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= `MBO_ST_IDLE;
      op_q <= `MBO_OP_EQV;
      widx_q <= {PW{1'b0}};
      cur_q <= {PW{1'b0}};
      worda_q <= 16'h0000;
      wordb_q <= 16'h0000;
      held_q <= 1'b0;
      wrap_q <= 1'b0;
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_mem_addr <= {AW{1'b0}};
      o_mem_wdata <= 16'h0000;
      o_bit_pointer <= {PW{1'b0}};
      o_match_found_flag <= 1'b0;
      o_end_flag <= 1'b0;
      o_ptr_error_flag <= 1'b0;
      o_read_out_bit <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_done <= 1'b0;
      case (st_q)
        `MBO_ST_IDLE: begin
          if (i_ptr_load) begin
            o_bit_pointer <= i_ptr_load_val;
          end else if (i_pointer_zero_input && !(fire && len_ok)) begin
            o_bit_pointer <= {PW{1'b0}};
          end
          if (fire && len_ok) begin
            op_q <= i_op;
            o_match_found_flag <= 1'b0;
            o_end_flag <= 1'b0;
            o_ptr_error_flag <= 1'b0;
            widx_q <= {PW{1'b0}};
            case (i_op)
              `MBO_OP_EQV, `MBO_OP_INV: begin
                o_busy <= 1'b1;
                o_mem_rd <= 1'b1;
                o_mem_addr <= i_source_a_base;
                st_q <= `MBO_ST_RDA;
              end
              `MBO_OP_CMP: begin
                if (o_bit_pointer > last_idx) begin
                  o_ptr_error_flag <= 1'b1;
                  o_done <= 1'b1;
                end else begin
                  // Restart from the top after a finished sweep or on request.
                  if (i_search_from_top || o_bit_pointer == last_idx) begin
                    cur_q <= {PW{1'b0}};
                  end else begin
                    cur_q <= o_bit_pointer + {{(PW-1){1'b0}}, 1'b1};
                  end
                  wrap_q <= 1'b1;
                  o_busy <= 1'b1;
                  st_q <= `MBO_ST_RDA;
                end
              end
              `MBO_OP_BRD, `MBO_OP_BWR: begin
                o_bit_pointer <= ptr_eff;
                if (ptr_bad) begin
                  o_ptr_error_flag <= 1'b1;
                  o_done <= 1'b1;
                end else begin
                  cur_q <= ptr_eff;
                  o_mem_rd <= 1'b1;
                  o_mem_addr <= (i_op == `MBO_OP_BRD ? i_source_a_base : i_destination_base)
                                + ptr_eff[PW-1:`MBO_BIT_IDX_W];
                  o_busy <= 1'b1;
                  st_q <= (i_op == `MBO_OP_BRD) ? `MBO_ST_BRD : `MBO_ST_WR;
                end
              end
              default: begin
                o_done <= 1'b1;
              end
            endcase
          end
        end
        `MBO_ST_RDA: begin
          if (op_q == `MBO_OP_CMP) begin
            if (wrap_q) begin
              // Fetch the word pair that holds the current bit.
              wrap_q <= 1'b0;
              o_mem_rd <= 1'b1;
              o_mem_addr <= i_source_a_base + cur_word;
              st_q <= `MBO_ST_RDA;
              widx_q <= {PW{1'b0}};
            end else if (widx_q == {PW{1'b0}}) begin
              widx_q <= {{(PW-1){1'b0}}, 1'b1};
            end else begin
              worda_q <= i_mem_rdata;
              o_mem_rd <= 1'b1;
              o_mem_addr <= i_source_b_base + cur_word;
              st_q <= `MBO_ST_RDB;
              widx_q <= {PW{1'b0}};
            end
          end else if (!wrap_q) begin
            wrap_q <= 1'b1;
          end else begin
            wrap_q <= 1'b0;
            if (op_q == `MBO_OP_INV) begin
              o_mem_wdata <= ~i_mem_rdata;
              o_mem_wr <= 1'b1;
              o_mem_addr <= i_destination_base + widx_q;
              st_q <= `MBO_ST_WR;
            end else begin
              worda_q <= i_mem_rdata;
              o_mem_rd <= 1'b1;
              o_mem_addr <= i_source_b_base + widx_q;
              st_q <= `MBO_ST_RDB;
            end
          end
        end
        `MBO_ST_RDB: begin
          if (!wrap_q) begin
            wrap_q <= 1'b1;
          end else begin
            wrap_q <= 1'b0;
            if (op_q == `MBO_OP_CMP) begin
              wordb_q <= b_word;
              held_q <= 1'b0;
              if (pair_hit) begin
                o_bit_pointer <= cur_q;
                o_match_found_flag <= 1'b1;
                if (cur_q == last_idx) begin
                  o_end_flag <= 1'b1;
                end
                st_q <= `MBO_ST_DONE;
              end else if (cur_q == last_idx) begin
                o_bit_pointer <= last_idx;
                o_end_flag <= 1'b1;
                st_q <= `MBO_ST_DONE;
              end else begin
                cur_q <= cur_q + {{(PW-1){1'b0}}, 1'b1};
                if (cur_bit == 4'hf) begin
                  wrap_q <= 1'b1;
                  st_q <= `MBO_ST_RDA;
                end else begin
                  // The held word lets the next bit be checked in the next cycle.
                  held_q <= 1'b1;
                  wrap_q <= 1'b1;
                end
              end
            end else begin
              o_mem_wdata <= ~(worda_q ^ i_mem_rdata);
              o_mem_wr <= 1'b1;
              o_mem_addr <= i_destination_base + widx_q;
              st_q <= `MBO_ST_WR;
            end
          end
        end
        `MBO_ST_WR: begin
          if (op_q == `MBO_OP_BWR) begin
            if (!wrap_q) begin
              wrap_q <= 1'b1;
            end else begin
              wrap_q <= 1'b0;
              o_mem_wdata <= i_write_value_bit ? (i_mem_rdata | sel_mask)
                                               : (i_mem_rdata & ~sel_mask);
              o_mem_wr <= 1'b1;
              if (o_bit_pointer == last_idx) begin
                o_end_flag <= 1'b1;
              end else if (i_step) begin
                o_bit_pointer <= o_bit_pointer + {{(PW-1){1'b0}}, 1'b1};
              end
              st_q <= `MBO_ST_DONE;
            end
          end else if (widx_q + {{(PW-1){1'b0}}, 1'b1} == i_len) begin
            st_q <= `MBO_ST_DONE;
          end else begin
            widx_q <= widx_q + {{(PW-1){1'b0}}, 1'b1};
            o_mem_rd <= 1'b1;
            o_mem_addr <= i_source_a_base + widx_q + {{(PW-1){1'b0}}, 1'b1};
            st_q <= `MBO_ST_RDA;
          end
        end
        `MBO_ST_BRD: begin
          if (!wrap_q) begin
            wrap_q <= 1'b1;
          end else begin
            wrap_q <= 1'b0;
            o_read_out_bit <= i_mem_rdata[cur_bit];
            if (o_bit_pointer == last_idx) begin
              o_end_flag <= 1'b1;
            end else if (i_step) begin
              o_bit_pointer <= o_bit_pointer + {{(PW-1){1'b0}}, 1'b1};
            end
            st_q <= `MBO_ST_DONE;
          end
        end
        `MBO_ST_DONE: begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
          st_q <= `MBO_ST_IDLE;
        end
        default: begin
          st_q <= `MBO_ST_IDLE;
        end
      endcase
    end
  end
endmodule // mbo_matrix_unit

// [testbench/mbo_mem_model.sv]
// Word data memory on the far side of the matrix unit.
// Assumes one read pulse per word and read data sampled in the next cycle.
`timescale 1ns/1ps
module mbo_mem_model (
  input wire i_ref_clk,
  input wire i_rd,
  input wire i_wr,
  input wire [15:0] i_addr,
  input wire [15:0] i_wdata,
  output logic [15:0] o_rdata = 16'h0
);
  logic [15:0] mem [0:63];
  // Read data stand one cycle, then toggle every cycle so data sampled one cycle late look inverted.
  always @(posedge i_ref_clk) begin
    if (i_wr) mem[i_addr[5:0]] <= i_wdata;
    if (i_rd) o_rdata <= mem[i_addr[5:0]];
    else o_rdata <= ~o_rdata;
  end
endmodule // mbo_mem_model

// [testbench/mbo_asserts.sv]
// Port checker for the matrix bit operation unit.
// Assumes it is bound to mbo_matrix_unit and sees only its ports.
`timescale 1ns/1ps
`include "mbo_regs.vh"
module mbo_asserts #(
  parameter AW = 16,
  parameter PW = 16
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_en,
  input wire i_pulse_mode,
  input wire [2:0] i_op,
  input wire [AW-1:0] i_source_a_base,
  input wire [AW-1:0] i_destination_base,
  input wire [PW-1:0] i_len,
  input wire i_pointer_zero_input,
  input wire i_ptr_load,
  input wire o_mem_rd,
  input wire o_mem_wr,
  input wire [AW-1:0] o_mem_addr,
  input wire [PW-1:0] o_bit_pointer,
  input wire o_match_found_flag,
  input wire o_end_flag,
  input wire o_ptr_error_flag,
  input wire o_busy,
  input wire o_done
);
  wire [PW-1:0] nbits = {i_len[PW-5:0], 4'h0};
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  property p_level;
    !o_busy && !o_done && i_en && !i_pulse_mode && i_len >= 2 && i_op < `MBO_OP_CMP |=> o_busy;
  endproperty
  a_level: assert property (p_level) else $error("level enable ignored");
  property p_rd_addr;
    $rose(o_busy) && i_op == `MBO_OP_BRD && !i_pointer_zero_input && o_bit_pointer < nbits
      |-> o_mem_rd && o_mem_addr == i_source_a_base + (o_bit_pointer >> 4);
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("bit read word address wrong");
  property p_wr_clr;
    $rose(o_busy) && i_op == `MBO_OP_BWR && i_pointer_zero_input |-> o_mem_addr == i_destination_base;
  endproperty
  a_wr_clr: assert property (p_wr_clr) else $error("bit write ignored pointer clear");
  property p_err;
    $rose(o_ptr_error_flag) |-> o_bit_pointer >= nbits;
  endproperty
  a_err: assert property (p_err) else $error("error flag with pointer in range");
  property p_err_quiet;
    o_ptr_error_flag |-> !o_mem_wr;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("memory written after pointer error");
  property p_end;
    o_done && o_end_flag |-> o_bit_pointer == nbits - 1'b1;
  endproperty
  a_end: assert property (p_end) else $error("end flag with pointer not last");
  property p_found;
    o_done && o_match_found_flag |-> o_bit_pointer < nbits && !o_ptr_error_flag;
  endproperty
  a_found: assert property (p_found) else $error("found flag with bad pointer");
  property p_clr;
    !o_busy && !o_done && !i_en && i_pointer_zero_input && !i_ptr_load |=> o_bit_pointer == 0;
  endproperty
  a_clr: assert property (p_clr) else $error("idle pointer clear ignored");
endmodule // mbo_asserts
bind mbo_matrix_unit mbo_asserts #(.AW(AW), .PW(PW)) mbo_asserts_inst (.*);

// [testbench/test_matrix_bit_ops_unit.sv]
// Self-checking bench for the matrix bit operation unit.
// Assumes the memory model as word store; L is two words.
`timescale 1ns/1ps
module test_matrix_bit_ops_unit;
  logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_en = 1'b0, i_pulse_mode = 1'b0, i_ptr_load = 1'b0;
  logic i_search_from_top = 1'b0, i_differ_sel = 1'b0, i_write_value_bit = 1'b0, i_step = 1'b0;
  logic i_pointer_zero_input = 1'b0;
  logic [2:0] i_op = 3'h0;
  logic [15:0] i_source_a_base = 16'h10, i_source_b_base = 16'h20, i_destination_base = 16'h30;
  logic [15:0] i_len = 16'h2, i_ptr_load_val = 16'h0;
  wire [15:0] i_mem_rdata, o_mem_addr, o_mem_wdata, o_bit_pointer;
  wire o_mem_rd, o_mem_wr, o_match_found_flag, o_end_flag, o_ptr_error_flag, o_read_out_bit, o_busy, o_done;
  int err_count = 0, n_tests = 0, dones = 0;
  always #4 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) if (o_done === 1'b1) dones <= dones + 1;
  mbo_matrix_unit mbo_matrix_unit_inst (.*);
  mbo_mem_model mbo_mem_model_inst (.i_ref_clk(i_ref_clk), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task load(input logic [15:0] v);
    @(posedge i_ref_clk);
    i_ptr_load <= 1'b1;
    i_ptr_load_val <= v;
    @(posedge i_ref_clk);
    i_ptr_load <= 1'b0;
  endtask
  // Flags are {from_top, differ, write value, step, pointer zero}.
  task run(input logic [2:0] op, input logic [4:0] f);
    @(posedge i_ref_clk);
    i_op <= op;
    {i_search_from_top, i_differ_sel, i_write_value_bit, i_step, i_pointer_zero_input} <= f;
    i_en <= 1'b1;
    @(posedge i_ref_clk);
    i_en <= 1'b0;
    #1;
    for (int k = 0; k < 300 && o_done !== 1'b1; k++) begin
      @(posedge i_ref_clk);
      #1;
    end
    check("done", o_done, 16'h1);
    i_pointer_zero_input <= 1'b0;
  endtask
  task res(input logic [15:0] p, input logic [2:0] f);
    check("pointer", o_bit_pointer, p);
    check("found end error", {13'h0, o_match_found_flag, o_end_flag, o_ptr_error_flag}, {13'h0, f});
  endtask
  task memchk(input int a, input logic [15:0] v);
    check("memory word", mbo_mem_model_inst.mem[a], v);
  endtask
  initial begin
    mbo_mem_model_inst.mem[16] = 16'h00f0;
    mbo_mem_model_inst.mem[17] = 16'h1234;
    mbo_mem_model_inst.mem[32] = 16'h0ff0;
    mbo_mem_model_inst.mem[33] = 16'hf0f0;
    mbo_mem_model_inst.mem[50] = 16'h0000;
    repeat (4) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    run(3'h0, 5'h00);
    @(posedge i_ref_clk);
    #1;
    memchk(48, 16'hf0ff);
    memchk(49, 16'h1d3b);
    $display("equivalence test ended");
    run(3'h4, 5'h03);
    res(16'h1, 3'h0);
    load(16'd30);
    run(3'h4, 5'h06);
    res(16'd31, 3'h0);
    run(3'h4, 5'h04);
    res(16'd31, 3'h2);
    @(posedge i_ref_clk);
    #1;
    memchk(48, 16'hf0fe);
    memchk(49, 16'hdd3b);
    $display("bit write test ended");
    load(16'd4);
    run(3'h3, 5'h00);
    check("read bit", o_read_out_bit, 1'b1);
    res(16'd4, 3'h0);
    run(3'h3, 5'h03);
    check("read bit", o_read_out_bit, 1'b0);
    res(16'd1, 3'h0);
    load(16'd31);
    run(3'h3, 5'h02);
    res(16'd31, 3'h2);
    $display("bit read test ended");
    run(3'h2, 5'h08);
    res(16'd8, 3'h4);
    run(3'h2, 5'h08);
    res(16'd9, 3'h4);
    run(3'h2, 5'h18);
    res(16'd8, 3'h4);
    load(16'd30);
    run(3'h2, 5'h00);
    res(16'd31, 3'h2);
    run(3'h2, 5'h00);
    res(16'd0, 3'h4);
    $display("compare test ended");
    for (int op = 2; op < 5; op++) begin
      load(16'd32);
      run(op[2:0], 5'h06);
      res(16'd32, 3'h1);
    end
    memchk(50, 16'h0000);
    $display("pointer error test ended");
    run(3'h1, 5'h00);
    @(posedge i_ref_clk);
    #1;
    memchk(48, 16'hff0f);
    memchk(49, 16'hedcb);
    load(16'd5);
    @(posedge i_ref_clk);
    i_pointer_zero_input <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1;
    check("pointer", o_bit_pointer, 16'h0);
    $display("complement and clear test ended");
    @(posedge i_ref_clk);
    i_pointer_zero_input <= 1'b0;
    i_op <= 3'h0;
    i_pulse_mode <= 1'b1;
    n_tests = n_tests;
    @(posedge i_ref_clk);
    i_en <= 1'b1;
    dones = 0;
    repeat (60) @(posedge i_ref_clk);
    i_en <= 1'b0;
    #1;
    check("runs in pulse form", dones[15:0], 16'h1);
    $display("pulse form test ended");
    finish_test();
  end
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
endmodule // test_matrix_bit_ops_unit
